/* File: rtl/hbc_device.sv */
// Bridge driver end: input decode, current chopping and overcurrent flag
// Operation
// - Sleep low: bridge high-Z, regulators off
// - Enable low: both outputs low brake
// - Enable high, direction low: reverse drive
// - Enable high, direction high: forward drive
// - PWM inputs both low: coast, regulators on
// - PWM A low, B high: reverse
// - PWM A high, B low: forward
// - PWM both high: low-side brake
// - Half-bridge enable/direction: controller holds direction low
// - Half-bridge: never enable and direction high
// - Half-bridge PWM: A high, B low forbidden
// - Chop threshold reached: brake for off-time
// - Ignore sense during blanking after enable
// - Compare twenty times shunt voltage with reference
// - Reference high, sense grounded: never chop
// - Shunt voltage above one volt: overcurrent
// - Both sense inputs grounded: regulation disabled
// - Chop off-time is twenty-five microseconds
// - Chop flag low only during internal chopping
// - Overcurrent must persist deglitch time first
//
// The register addresses and register access over AHB-Lite were decided locally.
`timescale 1ns/10ps
`include "hbc_cfg.svh"

module hbc_device #(
	parameter int SENSE_W     = 12,
	parameter int CNT_W       = 16,
	parameter int OFF_CYCLES  = `HBC_OFF_CYCLES,
	parameter int BLANK_CYCLES = `HBC_BLANK_CYCLES,
	parameter int OCP_CYCLES  = `HBC_OCP_CYCLES
) (
	input  wire logic                 hclk,
	input  wire logic                 hresetn,
	input  wire logic                 clk_en,
	input  wire logic                 variant_pwm_strap,
	input  wire logic [SENSE_W-1:0]   sense_pos,
	input  wire logic [SENSE_W-1:0]   sense_neg,
	input  wire logic [SENSE_W+4:0]   vref_mv,
	hbc_link_if.device                link,
	output logic                      high_gate_a,
	output logic                      low_gate_a,
	output logic                      high_gate_b,
	output logic                      low_gate_b,
	output logic                      analog_ldo_rail,
	output logic                      digital_ldo_rail
);
	import hbc_pkg::*;

	localparam int AMP_W = SENSE_W + 5;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic hbc_cmd_t decode_inputs(
		input logic pwm,
		input logic awake,
		input logic en,
		input logic dir,
		input logic in_a,
		input logic in_b
	);
		hbc_cmd_t c;
		c = HBC_CMD_SLEEP;
		if (!awake) begin
			c = HBC_CMD_SLEEP;
		end else if (pwm) begin
			unique case ({in_a, in_b})
				2'b00: c = HBC_CMD_COAST;
				2'b01: c = HBC_CMD_REV;
				2'b10: c = HBC_CMD_FWD;
				2'b11: c = HBC_CMD_BRAKE;
			endcase
		end else begin
			if (!en) begin
				c = HBC_CMD_BRAKE;
			end else if (dir) begin
				c = HBC_CMD_FWD;
			end else begin
				c = HBC_CMD_REV;
			end
		end
		return c;
	endfunction

	function automatic logic [3:0] gate_pattern(input hbc_cmd_t c);
		logic [3:0] g;
		g = 4'h0;
		// Order: high A, low A, high B, low B
		unique case (c)
			HBC_CMD_SLEEP: g = 4'b0000;
			HBC_CMD_COAST: g = 4'b0000;
			HBC_CMD_BRAKE: g = 4'b0101;
			HBC_CMD_FWD:   g = 4'b1001;
			HBC_CMD_REV:   g = 4'b0110;
		endcase
		return g;
	endfunction

	// ----------------------------------------------------------------
	// Variant strap: three-stage capture after reset release
	// ----------------------------------------------------------------
	logic [2:0] strap_sync;
	logic       strap_done;
	logic       variant_pwm;
	logic [2:0] next_strap_sync;
	logic       next_strap_done;
	logic       next_variant_pwm;

	always_comb begin
		next_strap_sync  = {strap_sync[1:0], variant_pwm_strap};
		next_strap_done  = strap_done;
		next_variant_pwm = variant_pwm;
		// Reset pattern keeps stages two and three apart until the pin arrives
		if (!strap_done && (strap_sync[1] == strap_sync[2])) begin
			next_strap_done  = 1'b1;
			next_variant_pwm = strap_sync[2];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			strap_sync  <= 3'h2;
			strap_done  <= 1'b0;
			variant_pwm <= 1'b0;
		end else if (clk_en) begin
			strap_sync  <= next_strap_sync;
			strap_done  <= next_strap_done;
			variant_pwm <= next_variant_pwm;
		end
	end

	// ----------------------------------------------------------------
	// Sense evaluation
	// ----------------------------------------------------------------
	logic [AMP_W-1:0] shunt_mv;
	logic [AMP_W-1:0] amp_mv;
	logic             reg_disabled;
	logic             chop_trip;
	logic             ocp_raw;

	always_comb begin
		shunt_mv = '0;
		if (sense_pos > sense_neg) begin
			shunt_mv = AMP_W'(sense_pos - sense_neg);
		end
		amp_mv = AMP_W'(shunt_mv * AMP_W'(`HBC_AMP_GAIN));
		reg_disabled = (sense_pos == '0) && (sense_neg == '0);
		// tied-off inputs never reach the trip
		chop_trip = !reg_disabled && (amp_mv >= vref_mv);
		// above one volt across the shunt
		ocp_raw = shunt_mv > AMP_W'(`HBC_OCP_LIMIT_MV);
	end

	// ----------------------------------------------------------------
	// Overcurrent deglitch
	// ----------------------------------------------------------------
	logic [CNT_W-1:0] ocp_cnt;
	logic             ocp_flag;
	logic [CNT_W-1:0] next_ocp_cnt;
	logic             next_ocp_flag;

	always_comb begin
		next_ocp_cnt  = '0;
		next_ocp_flag = 1'b0;
		// condition must hold the whole deglitch time
		if (ocp_raw) begin
			next_ocp_cnt  = ocp_cnt;
			next_ocp_flag = ocp_flag;
			if (ocp_cnt == CNT_W'(OCP_CYCLES - 1)) begin
				next_ocp_flag = 1'b1;
			end else begin
				next_ocp_cnt = ocp_cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ocp_cnt  <= '0;
			ocp_flag <= 1'b0;
		end else if (clk_en) begin
			ocp_cnt  <= next_ocp_cnt;
			ocp_flag <= next_ocp_flag;
		end
	end

	// ----------------------------------------------------------------
	// Chopper sequencing
	// ----------------------------------------------------------------
	hbc_cmd_t         cmd;
	hbc_cmd_t         last_cmd;
	hbc_state_t       state;
	logic [CNT_W-1:0] tmr;
	hbc_state_t       next_state;
	logic [CNT_W-1:0] next_tmr;
	logic [3:0]       next_gates;
	logic             drive_cmd;

	always_comb begin
		cmd = decode_inputs(variant_pwm, link.sleep_request_low, link.enable_input,
			link.direction_input, link.control_a_input, link.control_b_input);
		drive_cmd  = (cmd == HBC_CMD_FWD) || (cmd == HBC_CMD_REV);
		next_state = state;
		next_tmr   = tmr;
		if (!drive_cmd) begin
			next_state = HBC_ST_IDLE;
			next_tmr   = '0;
		end else if (state == HBC_ST_IDLE || cmd != last_cmd) begin
			// new drive starts with sense ignored
			next_state = HBC_ST_BLANK;
			next_tmr   = '0;
		end else begin
			unique case (state)
				HBC_ST_BLANK: begin
					if (tmr == CNT_W'(BLANK_CYCLES - 1)) begin
						next_state = HBC_ST_ARMED;
						next_tmr   = '0;
					end else begin
						next_tmr = tmr + 1'b1;
					end
				end
				HBC_ST_ARMED: begin
					if (chop_trip) begin
						next_state = HBC_ST_CHOPPING;
						next_tmr   = '0;
					end
				end
				HBC_ST_CHOPPING: begin
					if (tmr == CNT_W'(OFF_CYCLES - 1)) begin
						// resume drive through a fresh blanking
						next_state = HBC_ST_BLANK;
						next_tmr   = '0;
					end else begin
						next_tmr = tmr + 1'b1;
					end
				end
				HBC_ST_IDLE: next_state = HBC_ST_BLANK;
			endcase
		end
		next_gates = gate_pattern(cmd);
		if (next_state == HBC_ST_CHOPPING) begin
			next_gates = gate_pattern(HBC_CMD_BRAKE);
		end
		// Overcurrent releases every gate, the safest state without retry logic
		if (next_ocp_flag) begin
			next_gates = 4'b0000;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state    <= HBC_ST_IDLE;
			tmr      <= '0;
			last_cmd <= HBC_CMD_SLEEP;
		end else if (clk_en) begin
			state    <= next_state;
			tmr      <= next_tmr;
			last_cmd <= cmd;
		end
	end

	// ----------------------------------------------------------------
	// Registered outputs
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{high_gate_a, low_gate_a, high_gate_b, low_gate_b} <= 4'h0;
			analog_ldo_rail   <= 1'b0;
			digital_ldo_rail  <= 1'b0;
			link.chop_flag_out <= 1'b0;
			link.chop_flag_oe <= 1'b0;
			link.overcurrent_flag <= 1'b0;
		end else if (clk_en) begin
			{high_gate_a, low_gate_a, high_gate_b, low_gate_b} <= next_gates;
			analog_ldo_rail   <= link.sleep_request_low;
			digital_ldo_rail  <= link.sleep_request_low;
			link.chop_flag_out <= 1'b0;
			// pulled low only in chop braking
			link.chop_flag_oe <= (next_state == HBC_ST_CHOPPING) && !next_ocp_flag;
			link.overcurrent_flag <= next_ocp_flag;
		end
	end

endmodule

/* File: rtl/hbc_cfg.svh */
// Constants for the H-bridge control and chopper block
`ifndef HBC_CFG_SVH
`define HBC_CFG_SVH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define HBC_CLK_PERIOD_NS   4
`define HBC_BLANK_TIME_NS   2000
`define HBC_OFF_TIME_US     25
`define HBC_OCP_DEGLITCH_NS 4500
// Least times round up to whole cycles
`define HBC_BLANK_CYCLES ((`HBC_BLANK_TIME_NS + `HBC_CLK_PERIOD_NS - 1) / `HBC_CLK_PERIOD_NS)
`define HBC_OFF_CYCLES   ((`HBC_OFF_TIME_US * 1000 + `HBC_CLK_PERIOD_NS - 1) / `HBC_CLK_PERIOD_NS)
`define HBC_OCP_CYCLES   ((`HBC_OCP_DEGLITCH_NS + `HBC_CLK_PERIOD_NS - 1) / `HBC_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Analog figures: amplifier gain, and overcurrent limit in millivolts
// ----------------------------------------------------------------
`define HBC_AMP_GAIN      20
`define HBC_OCP_LIMIT_MV  1000

// ----------------------------------------------------------------
// Controller register map
// ----------------------------------------------------------------
`define HBC_REG_CTRL      8'h00
`define HBC_REG_STATUS    8'h04
`define HBC_CTRL_RESET    32'h00000000
`define HBC_CTRL_AWAKE    0
`define HBC_CTRL_ENABLE   1
`define HBC_CTRL_DIR      2
`define HBC_CTRL_IN_A     3
`define HBC_CTRL_IN_B     4
`define HBC_CTRL_HALF     5
`define HBC_CTRL_PWM      6
`define HBC_ST_CHOP       0
`define HBC_ST_OCP        1
`define HBC_ST_REFUSED    2

`endif

/* File: rtl/hbc_pkg.sv */
// Types shared by both ends of the H-bridge control link
package hbc_pkg;

	typedef enum logic [2:0] {
		HBC_CMD_SLEEP,
		HBC_CMD_COAST,
		HBC_CMD_BRAKE,
		HBC_CMD_FWD,
		HBC_CMD_REV
	} hbc_cmd_t;

	typedef enum logic [1:0] {
		HBC_ST_IDLE,
		HBC_ST_BLANK,
		HBC_ST_ARMED,
		HBC_ST_CHOPPING
	} hbc_state_t;

endpackage

/* File: rtl/hbc_link_if.sv */
// Link between the motor controller and the bridge driver
`timescale 1ns/10ps

interface hbc_link_if;
	logic sleep_request_low;
	logic enable_input;
	logic direction_input;
	logic control_a_input;
	logic control_b_input;
	logic chop_flag_out;
	logic chop_flag_oe;
	logic chop_active_flag;
	logic overcurrent_flag;

	// Open-drain line with an external pull-up
	assign chop_active_flag = chop_flag_oe ? chop_flag_out : 1'b1;

	modport device (
		input  sleep_request_low,
		input  enable_input,
		input  direction_input,
		input  control_a_input,
		input  control_b_input,
		input  chop_active_flag,
		output chop_flag_out,
		output chop_flag_oe,
		output overcurrent_flag
	);

	modport controller (
		output sleep_request_low,
		output enable_input,
		output direction_input,
		output control_a_input,
		output control_b_input,
		input  chop_active_flag,
		input  overcurrent_flag
	);
endinterface

/* File: rtl/hbc_controller.sv */
// Controller end: AHB-Lite register slave that drives the bridge inputs
`timescale 1ns/10ps
`include "hbc_cfg.svh"

module hbc_controller (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        clk_en,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	hbc_link_if.controller   link
);
	import hbc_pkg::*;

	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	logic [31:0] ctrl;
	logic        refused;
	logic        wr_pend;
	logic [7:0]  wr_addr;
	logic [31:0] next_ctrl;
	logic        next_refused;
	logic        next_wr_pend;
	logic [7:0]  next_wr_addr;
	logic [31:0] next_hrdata;
	logic [31:0] status;
	logic        take;
	logic        half_ph;
	logic        half_pwm;
	logic        bad_cmd;

	always_comb begin
		take     = hsel && htrans[1] && hready;
		half_ph  = ctrl[`HBC_CTRL_HALF] && !ctrl[`HBC_CTRL_PWM];
		half_pwm = ctrl[`HBC_CTRL_HALF] && ctrl[`HBC_CTRL_PWM];
		bad_cmd = (half_ph && ctrl[`HBC_CTRL_ENABLE] && ctrl[`HBC_CTRL_DIR])
			|| (half_pwm && ctrl[`HBC_CTRL_IN_A] && !ctrl[`HBC_CTRL_IN_B]);
		status = {29'h0, refused, link.overcurrent_flag, !link.chop_active_flag};
		next_wr_pend = take && hwrite;
		next_wr_addr = take ? haddr[7:0] : wr_addr;
		next_hrdata  = hrdata;
		if (take && !hwrite) begin
			unique case (haddr[7:0])
				`HBC_REG_CTRL:   next_hrdata = ctrl;
				`HBC_REG_STATUS: next_hrdata = status;
				default:         next_hrdata = 32'h00000000;
			endcase
		end
		next_ctrl    = ctrl;
		next_refused = refused;
		if (wr_pend && wr_addr == `HBC_REG_CTRL) begin
			next_ctrl = {25'h0, hwdata[6:0]};
		end
		if (wr_pend && wr_addr == `HBC_REG_STATUS && hwdata[`HBC_ST_REFUSED]) begin
			next_refused = 1'b0;
		end
		// Set wins over a clear in the same cycle
		if (bad_cmd) begin
			next_refused = 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl      <= `HBC_CTRL_RESET;
			refused   <= 1'b0;
			wr_pend   <= 1'b0;
			wr_addr   <= 8'h00;
			hrdata    <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else if (clk_en) begin
			ctrl      <= next_ctrl;
			refused   <= next_refused;
			wr_pend   <= next_wr_pend;
			wr_addr   <= next_wr_addr;
			hrdata    <= next_hrdata;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Link drive
	// ----------------------------------------------------------------
	logic next_dir;
	logic next_in_a;
	logic next_in_b;

	always_comb begin
		// direction held low in half-bridge enable/direction use
		next_dir  = half_ph ? 1'b0 : ctrl[`HBC_CTRL_DIR];
		next_in_a = ctrl[`HBC_CTRL_IN_A];
		next_in_b = ctrl[`HBC_CTRL_IN_B];
		if (half_pwm && next_in_a && !next_in_b) begin
			next_in_a = 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			link.sleep_request_low <= 1'b0;
			link.enable_input      <= 1'b0;
			link.direction_input   <= 1'b0;
			link.control_a_input   <= 1'b0;
			link.control_b_input   <= 1'b0;
		end else if (clk_en) begin
			link.sleep_request_low <= ctrl[`HBC_CTRL_AWAKE];
			link.enable_input      <= ctrl[`HBC_CTRL_ENABLE];
			link.direction_input   <= next_dir;
			link.control_a_input   <= next_in_a;
			link.control_b_input   <= next_in_b;
		end
	end

endmodule

/* File: verif/hbc_link_monitor.sv */
// Checker watching the controller to bridge link
`timescale 1ns/10ps

module hbc_link_monitor #(
	parameter int OFF_CYCLES   = 20,
	parameter int BLANK_CYCLES = 5
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic sleep_request_low,
	input wire logic enable_input,
	input wire logic direction_input,
	input wire logic control_a_input,
	input wire logic control_b_input,
	input wire logic chop_flag_out,
	input wire logic chop_flag_oe,
	input wire logic chop_active_flag,
	input wire logic overcurrent_flag
);
	logic [15:0] run, next_run, gap, next_gap;
	logic [4:0]  ins, last_ins;
	logic        clean, next_clean, drive_cmd;

	assign ins = {sleep_request_low, enable_input, direction_input, control_a_input,
		control_b_input};
	assign drive_cmd = sleep_request_low && (enable_input || control_a_input != control_b_input);

	// Exact off-time is only claimed when nothing disturbed the chop window
	always_comb begin
		next_run   = chop_flag_oe ? run + 16'h1 : 16'h0;
		next_gap   = chop_flag_oe ? 16'h0 : gap + 16'(gap != 16'hFFFF);
		next_clean = (clean || !chop_flag_oe) && !overcurrent_flag && ins == last_ins;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			run      <= 16'h0;
			gap      <= 16'h0;
			clean    <= 1'b0;
			last_ins <= 5'h0;
		end else begin
			run      <= next_run;
			gap      <= next_gap;
			clean    <= next_clean;
			last_ins <= ins;
		end
	end

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	chk_line_pulled: assert property (
		chop_flag_oe |-> !chop_active_flag && !chop_flag_out)
		else $error("chop line not pulled low");
	chk_line_idle: assert property (
		!chop_flag_oe |-> chop_active_flag)
		else $error("chop line low while not chopping");
	chk_off_bound: assert property (
		chop_flag_oe |-> run < OFF_CYCLES)
		else $error("chop window too long");
	chk_off_exact: assert property (
		$fell(chop_flag_oe) && clean && !overcurrent_flag |-> run == OFF_CYCLES)
		else $error("chop window ended early");
	chk_blank_gap: assert property (
		$rose(chop_flag_oe) |-> gap >= BLANK_CYCLES)
		else $error("chop started inside blanking");
	chk_sleep_quiet: assert property (
		!sleep_request_low [*3] |-> !chop_flag_oe)
		else $error("chopping while asleep");
	chk_ocp_no_chop: assert property (
		overcurrent_flag [*2] |-> !chop_flag_oe)
		else $error("chop flag during overcurrent");
	chk_chop_drive: assert property (
		$rose(chop_flag_oe) |-> $past(drive_cmd) || $past(drive_cmd, 2))
		else $error("chop started outside drive");
endmodule

/* File: verif/hbridge_control_chopper_bench.sv */
// Bench joining controller and bridge driver through the link
`timescale 1ns/10ps

module hbridge_control_chopper_bench;
	localparam int OFF  = 20;
	localparam int BLK  = 5;
	localparam int OCPC = 8;

	logic        hclk, hresetn, strap, hready_o, hwrite, hresp_o;
	logic        ha, la, hb, lb, ar, dr;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [11:0] sp, sn;
	logic [16:0] vref;
	int          bad_count, comparisons, n, lowrun, span;
	logic [15:0] tab [14] = '{16'h0000, 16'h0600, 16'h0135, 16'h0535, 16'h0336, 16'h0739,
		16'h4130, 16'h5136, 16'h4939, 16'h5935, 16'h5800, 16'h7136, 16'h6930, 16'h6930};
	logic [11:0] cp [6] = '{12'h064, 12'h032, 12'h032, 12'h03C, 12'h000, 12'h000};
	logic [11:0] cn [6] = '{12'h000, 12'h000, 12'h000, 12'h00A, 12'h000, 12'h000};
	logic [16:0] cv [6] = '{17'h003E8, 17'h003E8, 17'h003E9, 17'h003E8, 17'h00000, 17'h1FFFF};
	logic [5:0]  ce = 6'h0B;

	hbc_link_if link ();

	hbc_controller hbc_controller_inst (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1),
		.hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hready_o), .hreadyout(hready_o), .hresp(hresp_o),
		.hrdata(hrdata), .link(link));

	hbc_device #(.OFF_CYCLES(OFF), .BLANK_CYCLES(BLK), .OCP_CYCLES(OCPC)) hbc_device_inst (
		.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .variant_pwm_strap(strap),
		.sense_pos(sp), .sense_neg(sn), .vref_mv(vref), .link(link), .high_gate_a(ha),
		.low_gate_a(la), .high_gate_b(hb), .low_gate_b(lb), .analog_ldo_rail(ar),
		.digital_ldo_rail(dr));

	hbc_link_monitor #(.OFF_CYCLES(OFF), .BLANK_CYCLES(BLK)) hbc_link_monitor_inst (
		.hclk(hclk), .hresetn(hresetn), .sleep_request_low(link.sleep_request_low),
		.enable_input(link.enable_input), .direction_input(link.direction_input),
		.control_a_input(link.control_a_input), .control_b_input(link.control_b_input),
		.chop_flag_out(link.chop_flag_out), .chop_flag_oe(link.chop_flag_oe),
		.chop_active_flag(link.chop_active_flag), .overcurrent_flag(link.overcurrent_flag));

	initial begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end

	// Length of the last completed low stretch of the chop line
	always @(posedge hclk) begin
		if (link.chop_active_flag === 1'b0) lowrun <= lowrun + 1;
		else begin
			if (lowrun != 0) span <= lowrun;
			lowrun <= 0;
		end
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	function automatic logic [31:0] gates();
		return {26'h0, ar, dr, ha, la, hb, lb};
	endfunction

	task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
		@(posedge hclk);
		haddr  <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hready_o !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready_o !== 1'b1);
		rd = hrdata;
		chk("hresp", 32'h0, hresp_o);
	endtask

	task automatic put(input logic [31:0] v);
		xfer(32'h0, 1'b1, v);
		repeat (4) @(posedge hclk);
	endtask

	task automatic rst(input logic s);
		hresetn <= 1'b0;
		strap   <= s;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (6) @(posedge hclk);
	endtask

	task automatic wait_line(input logic v);
		for (n = 0; n < 60 && link.chop_active_flag !== v; n++) @(posedge hclk);
	endtask

	task automatic chop(input int i);
		sp   <= cp[i];
		sn   <= cn[i];
		vref <= cv[i];
		put(32'h1);
		wait_line(1'b1);
		span = 0;
		put(32'h7);
		wait_line(1'b0);
		if (n < 60) begin
			chk("chop gates", 32'h35, gates());
			xfer(32'h4, 1'b0, 32'h0);
			chk("chop status", 32'h1, rd);
		end
		wait_line(1'b1);
		@(posedge hclk);
		chk("chop span", ce[i] ? OFF : 0, span);
		chk("drive back", 32'h39, gates());
	endtask

	task automatic ocp(input logic [11:0] v, input int hold, input logic e);
		int f;
		f = -1;
		sp <= v;
		for (n = 1; n <= hold; n++) begin
			@(posedge hclk);
			if (f < 0 && link.overcurrent_flag === 1'b1) f = n;
		end
		if (e) chk("ocp gates", 32'h30, gates());
		if (e) chk("ocp line", 32'h1, link.chop_active_flag);
		sp <= 12'h000;
		chk("ocp timing", e, f >= OCPC - 1 && f <= OCPC + 3);
		repeat (4) @(posedge hclk);
		chk("ocp clear", 1'b0, link.overcurrent_flag);
	endtask

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		hresetn = 1'b0;
		{strap, hwrite, htrans, haddr, hwdata, sp, sn, vref} = '0;
		{bad_count, comparisons, lowrun, span} = '0;
		rst(1'b0);
		xfer(32'h0, 1'b0, 32'h0);
		chk("ctrl reset", 32'h0, rd);
		xfer(32'h0, 1'b1, 32'hFFFFFFBF);
		xfer(32'h0, 1'b0, 32'h0);
		chk("ctrl", 32'h3F, rd);
		xfer(32'h10, 1'b1, 32'hFFFFFFFF);
		xfer(32'h10, 1'b0, 32'h0);
		chk("unmapped", 32'h0, rd);
		chk("half gates", 32'h36, gates());
		chk("half dir", 1'b0, link.direction_input);
		xfer(32'h4, 1'b1, 32'h4);
		xfer(32'h4, 1'b0, 32'h0);
		chk("refused", 32'h4, rd);
		put(32'h1);
		xfer(32'h4, 1'b1, 32'h4);
		xfer(32'h4, 1'b0, 32'h0);
		chk("refused clear", 32'h0, rd);
		$display("registers done");
		for (int i = 0; i < 14; i++) begin
			if (i == 6) rst(1'b1);
			if (i == 6) $display("enable variant done");
			if (i == 13) rst(1'b0);
			if (i < 13) put({24'h0, tab[i][15:8]});
			if (i < 13) chk("gates", tab[i][7:0], gates());
			if (i == 12) chk("half a", 1'b0, link.control_a_input);
		end
		$display("pwm variant done");
		for (int i = 0; i < 6; i++) chop(i);
		put(32'h1);
		sp   <= 12'h064;
		vref <= 17'h003E8;
		span = 0;
		repeat (30) @(posedge hclk);
		chk("input brake", 32'h0, span + lowrun);
		$display("chopping done");
		vref <= 17'h1FFFF;
		put(32'h7);
		ocp(12'h3E9, 40, 1'b1);
		ocp(12'h3E8, 40, 1'b0);
		ocp(12'h3E9, OCPC - 2, 1'b0);
		vref <= 17'h003E8;
		ocp(12'h3E9, 40, 1'b1);
		$display("overcurrent done");
		conclude();
	end

	initial begin
		#200000;
		bad_count++;
		$display("[ERR] watchdog expired");
		conclude();
	end
endmodule
